// ===== sbtc_pkg.sv
/*
  constants, field positions, register offsets and types of the split-capable
  16-bit timer/counter.
  assumes a single 250 MHz system clock and the plain register port of the top.
*/
`default_nettype none
package sbtc_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int SBTC_DW = 16;
  localparam int SBTC_AW = 4;
  localparam int SBTC_NCH_T0 = 4;
  localparam int SBTC_NCH_T1 = 2;
  localparam int SBTC_PRE_W = 10;

  // ***************************************************************
  // register offsets (word index on the register port)
  // ***************************************************************
  localparam logic [3:0] SBTC_A_CTRL = 4'h0;
  localparam logic [3:0] SBTC_A_EVCTRL = 4'h1;
  localparam logic [3:0] SBTC_A_FLAGS = 4'h2;
  localparam logic [3:0] SBTC_A_CNT = 4'h3;
  localparam logic [3:0] SBTC_A_PER = 4'h4;
  localparam logic [3:0] SBTC_A_PERBUF = 4'h5;
  localparam logic [3:0] SBTC_A_CC0 = 4'h6;
  localparam logic [3:0] SBTC_A_CCBUF0 = 4'ha;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int SBTC_F_CLKSEL = 0;
  localparam int SBTC_F_WGM = 4;
  localparam int SBTC_F_SPLIT = 6;
  localparam int SBTC_F_CAPMODE = 7;
  localparam int SBTC_F_CCEN = 8;
  localparam int SBTC_F_FILT = 12;
  localparam int SBTC_F_DIR = 13;
  localparam int SBTC_FL_OVF = 0;
  localparam int SBTC_FL_ERR = 1;
  localparam int SBTC_FL_CC = 2;
  localparam int SBTC_FL_HUNF = 6;
  localparam int SBTC_FL_W = 7;

  // ***************************************************************
  // encodings and reset values
  // ***************************************************************
  localparam logic [3:0] SBTC_CLK_OFF = 4'h0;
  localparam logic [3:0] SBTC_CLK_EVT = 4'h8;
  localparam logic [3:0] SBTC_CLK_CASC = 4'h9;
  localparam logic [1:0] SBTC_WG_NORMAL = 2'h0;
  localparam logic [1:0] SBTC_WG_FREQ = 2'h1;
  localparam logic [1:0] SBTC_WG_SS = 2'h2;
  localparam logic [1:0] SBTC_WG_DS = 2'h3;
  localparam logic [2:0] SBTC_EV_OFF = 3'h0;
  localparam logic [2:0] SBTC_EV_CAPT = 3'h1;
  localparam logic [2:0] SBTC_EV_FRQ = 3'h2;
  localparam logic [2:0] SBTC_EV_PW = 3'h3;
  localparam logic [2:0] SBTC_EV_UPDN = 3'h4;
  localparam logic [2:0] SBTC_EV_QDEC = 3'h5;
  localparam logic [2:0] SBTC_EV_RESTART = 3'h6;
  localparam logic [15:0] SBTC_PER_RST = 16'hffff;

  typedef enum logic {SBTC_SLOPE_UP = 1'b0, SBTC_SLOPE_DOWN = 1'b1} sbtc_slope_e;

endpackage
`default_nettype wire

// ===== sbtc_timer.sv
/*
  16-bit timer/counter with four (type zero) or two (type one) compare/capture
  channels, cascading, event control and, in type zero only, an 8-bit split mode with eight PWM outputs.
  assumes all inputs synchronous to clk_sys_i; register strobes are one cycle long.
*/
`timescale 1ns/1ns
`default_nettype none

module sbtc_timer
  import sbtc_pkg::*;
#(
  parameter bit TYPE_ONE = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [SBTC_AW-1:0] addr_i,
  input wire logic [SBTC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SBTC_DW-1:0] rdata_o,
  input wire logic [1:0] evt_i,
  input wire logic casc_i,
  input wire logic [3:0] cap_i,
  output logic [7:0] wave_o,
  output logic ovf_evt_o,
  output logic err_evt_o,
  output logic [3:0] cc_evt_o,
  output logic hunf_evt_o,
  output logic [4:0] dma_req_o
);

  // ***************************************************************
  // state
  // ***************************************************************
  localparam int NCH = TYPE_ONE ? SBTC_NCH_T1 : SBTC_NCH_T0;

  typedef struct packed {
    logic [3:0] clksel;
    logic [1:0] wgm;
    logic split;
    logic capmode;
    logic [3:0] ccen;
    logic filt_en;
    logic dir_down;
    logic [2:0] evact;
    logic [SBTC_FL_W-1:0] flags;
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] perbuf;
    logic perbv;
    logic [3:0][15:0] cc;
    logic [3:0][15:0] ccbuf;
    logic [3:0] ccbv;
    logic [SBTC_PRE_W-1:0] pre;
    sbtc_slope_e slope;
    logic [7:0] wave;
    logic [3:0][1:0] fsr;
    logic [3:0] filt;
    logic [3:0] pfilt;
    logic [1:0] pevt;
    logic [15:0] rdata;
    logic ovf_p;
    logic err_p;
    logic [3:0] cc_p;
    logic hunf_p;
  } sbtc_state_s;

  sbtc_state_s s;
  sbtc_state_s next_s;

  // prescaler mask for the divide settings 1..1024
  function automatic logic [SBTC_PRE_W-1:0] presc_mask(input logic [3:0] sel);
    case (sel)
      4'h2: presc_mask = 10'h001;
      4'h3: presc_mask = 10'h003;
      4'h4: presc_mask = 10'h007;
      4'h5: presc_mask = 10'h03f;
      4'h6: presc_mask = 10'h0ff;
      4'h7: presc_mask = 10'h3ff;
      default: presc_mask = 10'h000;
    endcase
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic tick;
    logic step_up;
    logic step_dn;
    logic upd;
    logic lunf;
    logic hunf;
    logic clr_cnt;
    logic [15:0] top;
    logic [SBTC_FL_W-1:0] set_fl;
    logic [SBTC_FL_W-1:0] clr_fl;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [7:0] lcnt;
    logic [7:0] hcnt;
    tick = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    upd = 1'b0;
    lunf = 1'b0;
    hunf = 1'b0;
    clr_cnt = 1'b0;
    set_fl = '0;
    clr_fl = '0;
    lcnt = s.cnt[7:0];
    hcnt = s.cnt[15:8];
    next_s = s;
    next_s.ovf_p = 1'b0;
    next_s.err_p = 1'b0;
    next_s.cc_p = '0;
    next_s.hunf_p = 1'b0;
    next_s.pevt = evt_i;
    next_s.rdata = '0;
    top = (s.wgm == SBTC_WG_FREQ) ? s.cc[0] : s.per;

    // clock source selection and cascade input
    next_s.pre = (s.clksel == SBTC_CLK_OFF) ? '0 : s.pre + 10'h001;
    if (s.clksel == SBTC_CLK_EVT) begin
      tick = evt_i[0] & ~s.pevt[0];
    end else if (s.clksel == SBTC_CLK_CASC) begin
      tick = casc_i;
    end else if (s.clksel != SBTC_CLK_OFF) begin
      tick = (s.pre & presc_mask(s.clksel)) == presc_mask(s.clksel);
    end

    // input filter: three equal samples when enabled
    for (int i = 0; i < NCH; i++) begin
      next_s.fsr[i] = {s.fsr[i][0], cap_i[i]};
      if (!s.filt_en || (cap_i[i] == s.fsr[i][0] && cap_i[i] == s.fsr[i][1])) begin
        next_s.filt[i] = cap_i[i];
      end
    end
    next_s.pfilt = s.filt;
    rise = s.filt & ~s.pfilt;
    fall = ~s.filt & s.pfilt;

    // step requests: clock, direction event or quadrature
    if (s.evact == SBTC_EV_QDEC) begin
      if (evt_i != s.pevt) begin
        step_up = evt_i[0] ^ s.pevt[1];
        step_dn = ~(evt_i[0] ^ s.pevt[1]);
      end
    end else if (tick) begin
      if (s.evact == SBTC_EV_UPDN) begin
        step_dn = evt_i[1];
        step_up = ~evt_i[1];
      end else begin
        step_dn = s.dir_down;
        step_up = ~s.dir_down;
      end
    end

    if (s.split && !TYPE_ONE) begin
      // split: two down counters on one clock
      if (tick) begin
        if (lcnt == 8'h00) begin
          lunf = 1'b1;
          lcnt = s.per[7:0];
        end else begin
          lcnt = lcnt - 8'h01;
        end
        if (hcnt == 8'h00) begin
          hunf = 1'b1;
          hcnt = s.per[15:8];
        end else begin
          hcnt = hcnt - 8'h01;
        end
        for (int i = 0; i < NCH; i++) begin
          if (s.ccen[i] && s.cnt[7:0] == s.cc[i][7:0]) begin
            set_fl[SBTC_FL_CC+i] = 1'b1;
            next_s.cc_p[i] = 1'b1;
          end
        end
      end
      next_s.cnt = {hcnt, lcnt};
      upd = lunf;
      for (int i = 0; i < NCH; i++) begin
        next_s.wave[i] = s.ccen[i] & (s.cnt[7:0] < s.cc[i][7:0]);
        next_s.wave[4+i] = s.ccen[i] & (s.cnt[15:8] < s.cc[i][15:8]);
      end
    end else begin
      // 16-bit counting
      if (s.wgm == SBTC_WG_DS && (step_up || step_dn)) begin
        if (s.slope == SBTC_SLOPE_UP) begin
          if (s.cnt >= top) begin
            next_s.slope = SBTC_SLOPE_DOWN;
            next_s.cnt = s.cnt - 16'h0001;
          end else begin
            next_s.cnt = s.cnt + 16'h0001;
          end
        end else if (s.cnt == 16'h0000) begin
          next_s.slope = SBTC_SLOPE_UP;
          next_s.cnt = 16'h0001;
          upd = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end else if (step_dn) begin
        if (s.cnt == 16'h0000) begin
          next_s.cnt = top;
          upd = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end else if (step_up) begin
        if (s.cnt >= top) begin
          next_s.cnt = 16'h0000;
          upd = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 16'h0001;
        end
      end
      if (s.evact == SBTC_EV_RESTART && evt_i[0] && !s.pevt[0]) begin
        clr_cnt = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
        if (s.capmode) begin
          // capture only, no waveform
          next_s.wave[i] = 1'b0;
          if (s.ccen[i]) begin
            if ((s.evact == SBTC_EV_CAPT && rise[i]) || (s.evact == SBTC_EV_FRQ && rise[i])
                || (s.evact == SBTC_EV_PW && fall[i])) begin
              next_s.cc[i] = s.cnt;
              set_fl[SBTC_FL_CC+i] = 1'b1;
              next_s.cc_p[i] = 1'b1;
              set_fl[SBTC_FL_ERR] = set_fl[SBTC_FL_ERR] | s.flags[SBTC_FL_CC+i];
            end
            if ((s.evact == SBTC_EV_FRQ || s.evact == SBTC_EV_PW) && rise[i]) begin
              clr_cnt = 1'b1;
            end
          end
        end else begin
          // compare match and waveforms
          if (s.ccen[i] && (step_up || step_dn) && s.cnt == s.cc[i]) begin
            set_fl[SBTC_FL_CC+i] = 1'b1;
            next_s.cc_p[i] = 1'b1;
          end
          unique case (s.wgm)
            SBTC_WG_NORMAL: next_s.wave[i] = 1'b0;
            SBTC_WG_FREQ: next_s.wave[i] = (i == 0) ? (s.wave[0] ^ (upd & s.ccen[0])) : 1'b0;
            SBTC_WG_SS: next_s.wave[i] = s.ccen[i] & (s.cnt < s.cc[i]);
            SBTC_WG_DS: next_s.wave[i] = s.ccen[i] & (s.cnt < s.cc[i]);
          endcase
        end
        next_s.wave[4+i] = 1'b0;
      end
      if (clr_cnt) begin
        next_s.cnt = 16'h0000;
      end
    end

    // buffer transfer on update condition
    if (upd) begin
      if (s.perbv) begin
        next_s.per = s.perbuf;
        next_s.perbv = 1'b0;
      end
      for (int i = 0; i < NCH; i++) begin
        if (s.ccbv[i] && !(s.capmode && !s.split)) begin
          next_s.cc[i] = s.ccbuf[i];
          next_s.ccbv[i] = 1'b0;
        end
      end
    end
    set_fl[SBTC_FL_OVF] = upd;
    set_fl[SBTC_FL_HUNF] = hunf;
    next_s.ovf_p = upd;
    next_s.hunf_p = hunf;
    next_s.err_p = set_fl[SBTC_FL_ERR];

    // register writes
    if (wr_i) begin
      unique case (addr_i)
        SBTC_A_CTRL: begin
          next_s.clksel = wdata_i[SBTC_F_CLKSEL+:4];
          next_s.wgm = wdata_i[SBTC_F_WGM+:2];
          next_s.split = wdata_i[SBTC_F_SPLIT] & ~TYPE_ONE;
          next_s.capmode = wdata_i[SBTC_F_CAPMODE];
          next_s.ccen = wdata_i[SBTC_F_CCEN+:4] & (TYPE_ONE ? 4'h3 : 4'hf);
          next_s.filt_en = wdata_i[SBTC_F_FILT];
          next_s.dir_down = wdata_i[SBTC_F_DIR];
        end
        SBTC_A_EVCTRL: next_s.evact = wdata_i[2:0];
        SBTC_A_FLAGS: clr_fl = wdata_i[SBTC_FL_W-1:0];
        SBTC_A_CNT: next_s.cnt = wdata_i;
        SBTC_A_PER, SBTC_A_PERBUF: begin
          next_s.perbuf = wdata_i;
          next_s.perbv = 1'b1;
        end
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (addr_i == SBTC_A_CC0 + 4'(i) || addr_i == SBTC_A_CCBUF0 + 4'(i)) begin
              next_s.ccbuf[i] = wdata_i;
              next_s.ccbv[i] = 1'b1;
            end
          end
        end
      endcase
    end
    // set wins over clear
    next_s.flags = (s.flags & ~clr_fl) | set_fl;

    // register reads
    if (rd_i) begin
      unique case (addr_i)
        SBTC_A_CTRL: next_s.rdata = {2'h0, s.dir_down, s.filt_en, s.ccen, s.capmode, s.split, s.wgm, s.clksel};
        SBTC_A_EVCTRL: next_s.rdata = {13'h0000, s.evact};
        SBTC_A_FLAGS: next_s.rdata = {9'h000, s.flags};
        SBTC_A_CNT: next_s.rdata = s.cnt;
        SBTC_A_PER: next_s.rdata = s.per;
        SBTC_A_PERBUF: next_s.rdata = s.perbuf;
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (addr_i == SBTC_A_CC0 + 4'(i)) begin
              next_s.rdata = s.cc[i];
            end
            if (addr_i == SBTC_A_CCBUF0 + 4'(i)) begin
              next_s.rdata = s.ccbuf[i];
            end
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.per <= SBTC_PER_RST;
      s.perbuf <= SBTC_PER_RST;
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign rdata_o = s.rdata;
  assign wave_o = s.wave;
  assign ovf_evt_o = s.ovf_p;
  assign err_evt_o = s.err_p;
  assign cc_evt_o = s.cc_p;
  assign hunf_evt_o = s.hunf_p;
  assign dma_req_o = {s.flags[SBTC_FL_CC+:4], s.flags[SBTC_FL_OVF]};

endmodule
`default_nettype wire

// ===== sbtc_timer_assertions.sv
/*
  port checker for the split-capable timer.
  assumes it is bound to the top with TYPE_ONE handed on.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_timer_assertions
  import sbtc_pkg::*;
#(
  parameter bit TYPE_ONE = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [SBTC_AW-1:0] addr_i,
  input wire logic [SBTC_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [SBTC_DW-1:0] rdata_o,
  input wire logic [1:0] evt_i,
  input wire logic casc_i,
  input wire logic [3:0] cap_i,
  input wire logic [7:0] wave_o,
  input wire logic ovf_evt_o,
  input wire logic err_evt_o,
  input wire logic [3:0] cc_evt_o,
  input wire logic hunf_evt_o,
  input wire logic [4:0] dma_req_o
);
  // ****************************************
  // shadow of control registers
  // ****************************************
  logic [15:0] ctrl;
  logic [2:0] evc;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= 16'h0;
      evc <= 3'h0;
    end else if (wr_i && addr_i == SBTC_A_CTRL) begin
      ctrl <= wdata_i;
    end else if (wr_i && addr_i == SBTC_A_EVCTRL) begin
      evc <= wdata_i[2:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data not zero outside read answer");
  AST_RD_UNMAP: assert property (rd_i && addr_i >= 4'he |=> rdata_o == 16'h0)
    else $error("unmapped read not zero");
  AST_STOP: assert property (ctrl[3:0] == 4'h0 && $past(ctrl[3:0]) == 4'h0 && evc == 3'h0 |-> !ovf_evt_o)
    else $error("overflow while stopped");
  AST_HUNF: assert property (hunf_evt_o |-> !TYPE_ONE && (ctrl[SBTC_F_SPLIT] || $past(ctrl[SBTC_F_SPLIT])))
    else $error("high underflow outside split");
  AST_ERR: assert property (err_evt_o |-> ctrl[SBTC_F_CAPMODE] || $past(ctrl[SBTC_F_CAPMODE]))
    else $error("capture error in compare mode");
  AST_OVF_DMA: assert property (ovf_evt_o |-> dma_req_o[0])
    else $error("overflow event without request");
  AST_CC_DMA: assert property (cc_evt_o[0] |-> dma_req_o[1])
    else $error("channel event without request");
  AST_CLR: assert property (wr_i && addr_i == SBTC_A_FLAGS && wdata_i[0] |=> ovf_evt_o || !dma_req_o[0])
    else $error("request stays after clear");
  C_OVF: cover property (ovf_evt_o);
  C_HUNF: cover property (hunf_evt_o);
  C_ERR: cover property (err_evt_o);
  C_CC: cover property (cc_evt_o[0]);
endmodule
`default_nettype wire

// ===== sbtc_partner.sv
/*
  pins and event system around the timer.
  assumes requests from the bench are synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module sbtc_partner (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ev_on_i,
  input wire logic casc_on_i,
  input wire logic cap_req_i,
  output logic [1:0] evt_o,
  output logic casc_o,
  output logic [3:0] cap_o
);
  // ****************************************
  // event clock, cascade pulses, capture pin
  // ****************************************
  logic [1:0] cnt;
  logic [1:0] m3;
  logic [2:0] capc;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 2'h0;
      m3 <= 2'h0;
      capc <= 3'h0;
      evt_o <= 2'h0;
      casc_o <= 1'b0;
      cap_o <= 4'h0;
    end else begin
      cnt <= cnt + 2'h1;
      m3 <= (m3 == 2'h2) ? 2'h0 : m3 + 2'h1;
      evt_o[0] <= ev_on_i & cnt[1];
      evt_o[1] <= ev_on_i & (cnt[1] ^ cnt[0]);
      casc_o <= casc_on_i & (m3 == 2'h0);
      capc <= cap_req_i ? 3'h4 : (capc != 3'h0 ? capc - 3'h1 : 3'h0);
      cap_o <= {4{capc != 3'h0}};
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
/*
  self-checking bench of the split-capable timer.
  assumes the partner model drives the event and pin inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import sbtc_pkg::*;
  // ****************************************
  // clock, design, partner
  // ****************************************
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ev_on = 1'b0;
  logic casc_on = 1'b0;
  logic cap_req = 1'b0;
  wire logic [15:0] rdata_o;
  wire logic [1:0] evt_i;
  wire logic casc_i;
  wire logic [3:0] cap_i;
  wire logic [7:0] wave_o;
  wire logic ovf_evt_o;
  wire logic err_evt_o;
  wire logic [3:0] cc_evt_o;
  wire logic hunf_evt_o;
  wire logic [4:0] dma_req_o;
  wire logic [6:0] ev = {cc_evt_o, err_evt_o, hunf_evt_o, ovf_evt_o};
  int bad_count = 0;
  int num_checks = 0;
  int wc[8];
  int sel[6] = '{1, 2, 3, 4, 8, 9};
  int dv[6] = '{1, 2, 4, 8, 4, 3};
  int cl[4];
  int ch[4];
  always #2 clk_sys_i = ~clk_sys_i;
  sbtc_timer #(.TYPE_ONE(1'b0)) i_sbtc_timer (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt_i), .casc_i(casc_i),
    .cap_i(cap_i), .wave_o(wave_o), .ovf_evt_o(ovf_evt_o), .err_evt_o(err_evt_o), .cc_evt_o(cc_evt_o),
    .hunf_evt_o(hunf_evt_o), .dma_req_o(dma_req_o));
  sbtc_partner i_sbtc_partner (.clk_i(clk_sys_i), .rstn_i(rstn_i), .ev_on_i(ev_on), .casc_on_i(casc_on),
    .cap_req_i(cap_req), .evt_o(evt_i), .casc_o(casc_i), .cap_o(cap_i));
  // ****************************************
  // bus and measuring tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic gap(input int s, output int g);
    int n;
    int t;
    n = 0;
    g = 0;
    for (t = 0; t < 3000 && n < 3; t++) begin
      @(posedge clk_sys_i);
      #1 g++;
      if (ev[s] === 1'b1) begin
        n++;
        if (n < 3) g = 0;
      end
    end
  endtask
  task automatic meas(input int n);
    wc = '{default: 0};
    repeat (n) begin
      @(posedge clk_sys_i);
      #1 for (int k = 0; k < 8; k++) wc[k] += int'(wave_o[k] === 1'b1);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000 bad_count++;
    end_of_test();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [15:0] d;
    int g;
    int p;
    void'($urandom(32'h131a));
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(SBTC_A_PERBUF, d); `CHK(d, SBTC_PER_RST)
    rd(4'he, d); `CHK(d, 16'h0)
    wr(SBTC_A_PER, 16'h5);
    rd(SBTC_A_PER, d); `CHK(d, SBTC_PER_RST)
    wr(SBTC_A_CNT, 16'hfffd);
    wr(SBTC_A_CTRL, 16'h0001);
    gap(0, g); `CHK(g, 6)
    rd(SBTC_A_PER, d); `CHK(d, 16'h5)
    for (int i = 0; i < 6; i++) begin
      p = 2 + $urandom_range(7);
      ev_on <= (sel[i] == 8);
      casc_on <= (sel[i] == 9);
      wr(SBTC_A_PER, 16'(p));
      wr(SBTC_A_CTRL, 16'(sel[i]) | (16'(i & 1) << SBTC_F_DIR));
      gap(0, g); `CHK(g, (p + 1) * dv[i])
    end
    // quadrature steps count down once per input change
    wr(SBTC_A_EVCTRL, 16'(SBTC_EV_QDEC));
    ev_on <= 1'b1;
    wr(SBTC_A_CTRL, 16'h0);
    gap(0, g); `CHK(g, p + 1)
    ev_on <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    wr(SBTC_A_EVCTRL, 16'(SBTC_EV_OFF));
    wr(SBTC_A_PER, 16'h5);
    wr(SBTC_A_CNT, 16'hffff);
    for (int k = 0; k < 4; k++) begin
      cl[k] = $urandom_range(5);
      wr(SBTC_A_CCBUF0 + 4'(k), 16'(cl[k]));
    end
    wr(SBTC_A_CTRL, 16'h0f21);
    repeat (20) @(posedge clk_sys_i);
    meas(60);
    for (int k = 0; k < 4; k++) `CHK(wc[k], cl[k] * 10)
    `CHK(dma_req_o[4:1], 4'hf)
    wr(SBTC_A_CTRL, 16'h0);
    wr(SBTC_A_FLAGS, 16'h7f);
    #1 `CHK(dma_req_o, 5'h0)
    wr(SBTC_A_CNT, 16'h0505);
    wr(SBTC_A_CTRL, 16'h2041);
    rd(SBTC_A_CNT, d); `CHK(d[7:0] >= 8'h2 && d[7:0] <= 8'h5 && d[7:0] == d[15:8], 1'b1)
    wr(SBTC_A_CTRL, 16'h0);
    wr(SBTC_A_PER, 16'h0503);
    for (int k = 0; k < 4; k++) begin
      cl[k] = $urandom_range(4);
      ch[k] = $urandom_range(6);
      wr(SBTC_A_CCBUF0 + 4'(k), {8'(ch[k]), 8'(cl[k])});
    end
    wr(SBTC_A_CNT, 16'h0);
    wr(SBTC_A_CTRL, 16'h0f61);
    repeat (20) @(posedge clk_sys_i);
    meas(48);
    for (int k = 0; k < 4; k++) `CHK(wc[k] * 1000 + wc[k + 4], cl[k] * 12000 + ch[k] * 8)
    gap(0, g); `CHK(g, 4)
    gap(1, g); `CHK(g, 6)
    wr(SBTC_A_CTRL, 16'h0);
    wr(SBTC_A_FLAGS, 16'h7f);
    wr(SBTC_A_EVCTRL, 16'(SBTC_EV_CAPT));
    wr(SBTC_A_CTRL, 16'h0181);
    @(posedge clk_sys_i);
    cap_req <= 1'b1;
    @(posedge clk_sys_i);
    cap_req <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1 `CHK(dma_req_o[1], 1'b1)
    // second capture while the channel flag is still set is an overrun
    @(posedge clk_sys_i);
    cap_req <= 1'b1;
    @(posedge clk_sys_i);
    cap_req <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rd(SBTC_A_FLAGS, d); `CHK(d[SBTC_FL_ERR], 1'b1)
    end_of_test();
  end
endmodule
bind sbtc_timer sbtc_timer_assertions #(.TYPE_ONE(TYPE_ONE)) i_sbtc_timer_assertions (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .evt_i(evt_i), .casc_i(casc_i), .cap_i(cap_i), .wave_o(wave_o), .ovf_evt_o(ovf_evt_o),
  .err_evt_o(err_evt_o), .cc_evt_o(cc_evt_o), .hunf_evt_o(hunf_evt_o), .dma_req_o(dma_req_o));
`default_nettype wire
